// ===== hdl/sst_pkg.sv
// Constants and types shared by the system status block
package sst_pkg;

  // Block layout: byte offsets within the 16-byte status block
  localparam logic [3:0] OFF_RESET_CAUSE   = 4'h0;
  localparam logic [3:0] OFF_TRAP_CAUSE    = 4'h1;
  localparam logic [3:0] OFF_TRAP_LADDR_LO = 4'h2;
  localparam logic [3:0] OFF_TRAP_LADDR_HI = 4'h3;
  localparam logic [3:0] OFF_TRAP_PADDR_MD = 4'h4;
  localparam logic [3:0] OFF_TRAP_PADDR_HI = 4'h5;
  localparam logic [3:0] OFF_FLT_LADDR_LO  = 4'h6;
  localparam logic [3:0] OFF_FLT_LADDR_HI  = 4'h7;
  localparam logic [3:0] OFF_FLT_PADDR_MD  = 4'h8;
  localparam logic [3:0] OFF_FLT_PADDR_HI  = 4'h9;
  localparam logic [3:0] OFF_RSVD_A        = 4'ha;
  localparam logic [3:0] OFF_RSVD_B        = 4'hb;
  localparam logic [3:0] OFF_DMA_TIMEOUT   = 4'hc;
  localparam logic [3:0] OFF_WAIT_TIMEOUT  = 4'hd;
  localparam logic [3:0] OFF_PERIODIC_INT  = 4'he;
  localparam logic [3:0] OFF_EXT_INPUT     = 4'hf;

  // Instruction encoding and timing
  localparam logic [7:0] OPC_PREFIX    = 8'hed;
  localparam logic [7:0] OPC_XFER      = 8'h9a;
  localparam logic [5:0] XFER_CLOCKS   = 6'h28;  // 40 clocks
  localparam logic [5:0] WR_FIRST_CNT  = 6'h03;  // count before 1st byte
  localparam logic [5:0] WR_LAST_CNT   = 6'h22;  // count after 16th byte

  // Field positions
  localparam int RC_FATAL = 7;
  localparam int RC_FAULT = 6;
  localparam int RC_WDT   = 5;
  localparam int RC_POR   = 4;
  localparam int RC_LVL1  = 3;
  localparam int RC_EDG1  = 2;
  localparam int RC_LVL0  = 1;
  localparam int RC_EDG0  = 0;
  localparam int TC_WPROT = 3;
  localparam int TC_XINH  = 2;
  localparam int TC_ILL4  = 1;
  localparam int TC_ILL2  = 0;

  // Reset values
  localparam logic [7:0] RESET_CAUSE_RST = 8'h10;  // power-on flag set
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam logic [7:0] FLAG_BYTE       = 8'h01;
  localparam logic [7:0] SAT_BYTE        = 8'hff;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_TAIL  = 4'b1000
  } sst_state_t;

endpackage : sst_pkg

// ===== hdl/sst_status_block.sv
// System status collector and status block transfer engine
`timescale 1ns/10ps

// Function
// (R1) Sixteen bytes written from pointer, ascending
// (R2) Only dedicated opcode reads; 40 clocks
// (R3) Transfer and next instruction block interrupts
// (R4) Trap address latched on four trap events
// (R5) Trap address changes only on traps
// (R6) Latched address chosen by trap type
// (R7) Fault address captured on fault detect
// (R8) Addresses as four bytes, ascending offsets
// (R9) Offsets ten and eleven read zero
// (R10) Fatal, fault, watchdog flags sticky, read-cleared
// (R11) Power-on flag only from power-on clear
// (R12) Bits 3 and 1 show reset lines
// (R13) Reset line transitions sticky, read-cleared
// (R14) Trap cause flags sticky; write-protect clears
// (R15) DMA timeout flag or saturating count
// (R16) Wait timeout flag or saturating count
// (R17) Bit 5 is synchronized time reference
// (R18) Bit 4 flags divider below 1024
// (R19) Bit 3 shows continuous time reference
// (R20) Bit 2 shows generator synchronized
// (R21) Bits 1, 0 report default period use
// (R22) External inputs sampled first; read strobe after
// (R23) Event coinciding with clear stays set; the write-protect flag is cleared instead
module sst_status_block #(
  parameter bit DMA_COUNT_MODE  = 1'b0,  // 0 flag, 1 saturating count
  parameter bit WAIT_COUNT_MODE = 1'b0
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Instruction issue from the core
  input  wire logic        instr_start,
  input  wire logic [7:0]  opcode_byte0,
  input  wire logic [7:0]  opcode_byte1,
  input  wire logic        instr_end,
  input  wire logic [15:0] pointer_register,
  // Memory write port toward the core bus
  output logic             xfer_busy,
  output logic             xfer_done,
  output logic             mem_wr_en,
  output logic [15:0]      mem_wr_addr,
  output logic [7:0]       mem_wr_data,
  output logic [15:0]      pointer_next,
  output logic             int_inhibit,
  output logic             ext_stat_rd,
  // Trap sources
  input  wire logic        ill2_trap,
  input  wire logic        ill4_trap,
  input  wire logic [15:0] instr_laddr,
  input  wire logic [27:0] instr_paddr,
  input  wire logic        fetch_first,
  input  wire logic        exec_inh,
  input  wire logic        mem_write,
  input  wire logic        wr_inh,
  input  wire logic [15:0] mem_laddr,
  input  wire logic [27:0] mem_paddr,
  // Reset cause sources
  input  wire logic        fatal_detect,
  input  wire logic        fault_detect,
  input  wire logic        wdt_timeout,
  input  wire logic [1:0]  reset_bus,
  // Time-out monitors
  input  wire logic        dma_timeout,
  input  wire logic        wait_timeout,
  // Periodic interrupt generator state
  input  wire logic        ref_clock,
  input  wire logic        rti_div_small,
  input  wire logic        rti_ref_present,
  input  wire logic        rti_synced,
  input  wire logic        rti_dflt_small,
  input  wire logic        rti_dflt_used,
  // External status inputs
  input  wire logic [7:0]  ext_stat
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    sst_pkg::sst_state_t st;
    logic [5:0]          cnt;
    logic [15:0]         ptr;
    logic                busy;
    logic                done;
    logic                wr_en;
    logic [15:0]         wr_addr;
    logic [7:0]          wr_data;
    logic                inhibit;
    logic                rd_strobe;
    logic [7:0]          ext_snap;
    logic [7:0]          reset_cause;
    logic [3:0]          trap_cause;
    logic [7:0]          dma_byte;
    logic [7:0]          wait_byte;
    logic [1:0]          rbus_prev;
    logic                fault_prev;
    logic [1:0]          ref_sync;
  } sst_state_s_t;

  // Address store kept apart: it must survive every reset
  typedef struct packed {
    logic [15:0] trap_laddr;
    logic [27:0] trap_paddr;
    logic [15:0] flt_laddr;
    logic [27:0] flt_paddr;
  } sst_addr_t;

  sst_state_s_t s_q;
  sst_state_s_t s_d;
  sst_addr_t    a_q;
  sst_addr_t    a_d;

  logic         opc_hit;
  logic         xinh_ev;
  logic         wprot_ev;
  logic         fault_ev;
  logic [1:0]   rbus_edge;
  logic         clr;
  logic [3:0]   byte_idx;
  logic [5:0]   wr_rel;
  logic [7:0]   rc_live;
  logic [7:0]   rti_byte;
  logic [7:0]   sel_byte;

  ////////////////////////////////////////////////////////////////////////
  // Event decode

  // (R2) opcode match
  assign opc_hit   = instr_start &&
                     (opcode_byte0 == sst_pkg::OPC_PREFIX) &&
                     (opcode_byte1 == sst_pkg::OPC_XFER);
  // (R4) inhibit events
  assign xinh_ev   = exec_inh && fetch_first;
  assign wprot_ev  = wr_inh && mem_write;
  assign fault_ev  = fault_detect && !s_q.fault_prev;
  // (R13) line transitions
  assign rbus_edge = reset_bus ^ s_q.rbus_prev;
  // Flags clear on the edge that ends the transfer
  assign clr       = s_q.busy && (s_q.cnt == sst_pkg::XFER_CLOCKS - 6'h01);
  assign wr_rel    = s_q.cnt - sst_pkg::WR_FIRST_CNT;
  assign byte_idx  = wr_rel[4:1];

  // (R12) live reset line levels
  always_comb
  begin
    rc_live = s_q.reset_cause;
    rc_live[sst_pkg::RC_LVL1] = reset_bus[1];
    rc_live[sst_pkg::RC_LVL0] = reset_bus[0];
  end

  // (R18) (R19) (R20) (R21) generator flags passed as bits 4..0
  // (R17) synchronized reference and generator state
  assign rti_byte = {2'b00, s_q.ref_sync[1], rti_div_small, rti_ref_present,
                     rti_synced, rti_dflt_small, rti_dflt_used};

  ////////////////////////////////////////////////////////////////////////
  // Byte selection for the block

  always_comb
  begin
    // (R8) address byte layout
    if (byte_idx == sst_pkg::OFF_RESET_CAUSE)
      sel_byte = rc_live;
    else if (byte_idx == sst_pkg::OFF_TRAP_CAUSE)
      sel_byte = {4'h0, s_q.trap_cause};
    else if (byte_idx == sst_pkg::OFF_TRAP_LADDR_LO)
      sel_byte = a_q.trap_laddr[7:0];
    else if (byte_idx == sst_pkg::OFF_TRAP_LADDR_HI)
      sel_byte = a_q.trap_laddr[15:8];
    else if (byte_idx == sst_pkg::OFF_TRAP_PADDR_MD)
      sel_byte = a_q.trap_paddr[19:12];
    else if (byte_idx == sst_pkg::OFF_TRAP_PADDR_HI)
      sel_byte = a_q.trap_paddr[27:20];
    else if (byte_idx == sst_pkg::OFF_FLT_LADDR_LO)
      sel_byte = a_q.flt_laddr[7:0];
    else if (byte_idx == sst_pkg::OFF_FLT_LADDR_HI)
      sel_byte = a_q.flt_laddr[15:8];
    else if (byte_idx == sst_pkg::OFF_FLT_PADDR_MD)
      sel_byte = a_q.flt_paddr[19:12];
    else if (byte_idx == sst_pkg::OFF_FLT_PADDR_HI)
      sel_byte = a_q.flt_paddr[27:20];
    else if (byte_idx == sst_pkg::OFF_DMA_TIMEOUT)
      sel_byte = s_q.dma_byte;
    else if (byte_idx == sst_pkg::OFF_WAIT_TIMEOUT)
      sel_byte = s_q.wait_byte;
    else if (byte_idx == sst_pkg::OFF_PERIODIC_INT)
      sel_byte = rti_byte;
    else if (byte_idx == sst_pkg::OFF_EXT_INPUT)
      sel_byte = s_q.ext_snap;
    else
      // (R9) reserved bytes
      sel_byte = sst_pkg::ZERO_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer sequencer and status flags

  always_comb
  begin
    s_d           = s_q;
    s_d.done      = 1'b0;
    s_d.wr_en     = 1'b0;
    s_d.rd_strobe = s_q.done;
    s_d.ref_sync  = {s_q.ref_sync[0], ref_clock};
    s_d.rbus_prev = reset_bus;
    s_d.fault_prev = fault_detect;

    case (s_q.st)
      sst_pkg::ST_IDLE:
      begin
        if (opc_hit)
        begin
          s_d.st       = sst_pkg::ST_SETUP;
          s_d.busy     = 1'b1;
          s_d.cnt      = 6'h00;
          s_d.ptr      = pointer_register;
          // (R3) no interrupt sampling
          s_d.inhibit  = 1'b1;
          // (R22) sample in first state
          s_d.ext_snap = ext_stat;
        end
        else if (instr_end)
          // (R3) released after next instruction
          s_d.inhibit  = 1'b0;
      end
      sst_pkg::ST_SETUP:
      begin
        s_d.cnt = s_q.cnt + 6'h01;
        if (s_q.cnt == sst_pkg::WR_FIRST_CNT - 6'h01)
          s_d.st = sst_pkg::ST_WRITE;
      end
      sst_pkg::ST_WRITE:
      begin
        s_d.cnt = s_q.cnt + 6'h01;
        // (R1) one byte each two clocks
        if (!wr_rel[0])
        begin
          s_d.wr_en   = 1'b1;
          s_d.wr_addr = s_q.ptr;
          s_d.wr_data = sel_byte;
          s_d.ptr     = s_q.ptr + 16'h0001;
        end
        if (s_q.cnt == sst_pkg::WR_LAST_CNT)
          s_d.st = sst_pkg::ST_TAIL;
      end
      sst_pkg::ST_TAIL:
      begin
        s_d.cnt = s_q.cnt + 6'h01;
        // (R2) ends after 40 clocks
        if (clr)
        begin
          s_d.st   = sst_pkg::ST_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
      end
      default:
      begin
        s_d.st   = sst_pkg::ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase

    // (R10) sticky, set wins over clear
    s_d.reset_cause[sst_pkg::RC_FATAL] =
      (s_q.reset_cause[sst_pkg::RC_FATAL] && !clr) || fatal_detect;
    s_d.reset_cause[sst_pkg::RC_FAULT] =
      (s_q.reset_cause[sst_pkg::RC_FAULT] && !clr) || fault_ev;
    s_d.reset_cause[sst_pkg::RC_WDT] =
      (s_q.reset_cause[sst_pkg::RC_WDT] && !clr) || wdt_timeout;
    // (R11) only power-on reset sets it
    s_d.reset_cause[sst_pkg::RC_POR] =
      s_q.reset_cause[sst_pkg::RC_POR] && !clr;
    // (R13) transitions, set wins
    s_d.reset_cause[sst_pkg::RC_EDG1] =
      (s_q.reset_cause[sst_pkg::RC_EDG1] && !clr) || rbus_edge[1];
    s_d.reset_cause[sst_pkg::RC_EDG0] =
      (s_q.reset_cause[sst_pkg::RC_EDG0] && !clr) || rbus_edge[0];
    s_d.reset_cause[sst_pkg::RC_LVL1] = 1'b0;
    s_d.reset_cause[sst_pkg::RC_LVL0] = 1'b0;

    // (R14) write-protect clears at end regardless
    s_d.trap_cause[sst_pkg::TC_WPROT] =
      !clr && (s_q.trap_cause[sst_pkg::TC_WPROT] || wprot_ev);
    // (R23) other trap flags keep a coinciding event
    s_d.trap_cause[sst_pkg::TC_XINH] =
      (s_q.trap_cause[sst_pkg::TC_XINH] && !clr) || xinh_ev;
    s_d.trap_cause[sst_pkg::TC_ILL4] =
      (s_q.trap_cause[sst_pkg::TC_ILL4] && !clr) || ill4_trap;
    s_d.trap_cause[sst_pkg::TC_ILL2] =
      (s_q.trap_cause[sst_pkg::TC_ILL2] && !clr) || ill2_trap;

    // (R15) DMA time-out flag or count
    if (clr)
      s_d.dma_byte = dma_timeout ? sst_pkg::FLAG_BYTE : sst_pkg::ZERO_BYTE;
    else if (dma_timeout && !DMA_COUNT_MODE)
      s_d.dma_byte = sst_pkg::FLAG_BYTE;
    else if (dma_timeout && s_q.dma_byte != sst_pkg::SAT_BYTE)
      s_d.dma_byte = s_q.dma_byte + 8'h01;

    // (R16) wait time-out flag or count
    if (clr)
      s_d.wait_byte = wait_timeout ? sst_pkg::FLAG_BYTE : sst_pkg::ZERO_BYTE;
    else if (wait_timeout && !WAIT_COUNT_MODE)
      s_d.wait_byte = sst_pkg::FLAG_BYTE;
    else if (wait_timeout && s_q.wait_byte != sst_pkg::SAT_BYTE)
      s_d.wait_byte = s_q.wait_byte + 8'h01;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q             <= '0;
      s_q.st          <= sst_pkg::ST_IDLE;
      s_q.reset_cause <= sst_pkg::RESET_CAUSE_RST;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Trap and fault address store, no reset on purpose

  always_comb
  begin
    a_d = a_q;
    // (R6) address per trap type, write-protect first
    if (wprot_ev)
    begin
      a_d.trap_laddr = mem_laddr;
      a_d.trap_paddr = mem_paddr;
    end
    else if (xinh_ev)
    begin
      a_d.trap_laddr = mem_laddr;
      a_d.trap_paddr = mem_paddr;
    end
    else if (ill4_trap)
    begin
      // Third byte of the four-byte opcode
      a_d.trap_laddr = instr_laddr + 16'h0002;
      a_d.trap_paddr = instr_paddr + 28'h0000002;
    end
    else if (ill2_trap)
    begin
      a_d.trap_laddr = instr_laddr;
      a_d.trap_paddr = instr_paddr;
    end
    // (R7) capture bus address on fault
    if (fault_ev)
    begin
      a_d.flt_laddr = mem_laddr;
      a_d.flt_paddr = mem_paddr;
    end
  end

  // (R5) trap address updated only by traps, fault address only by faults
  always_ff @(posedge mclk)
  begin
    a_q <= a_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign xfer_busy    = s_q.busy;
  assign xfer_done    = s_q.done;
  assign mem_wr_en    = s_q.wr_en;
  assign mem_wr_addr  = s_q.wr_addr;
  assign mem_wr_data  = s_q.wr_data;
  assign pointer_next = s_q.ptr;
  assign int_inhibit  = s_q.inhibit;
  assign ext_stat_rd  = s_q.rd_strobe;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Count of write pulses inside one transfer
  logic [4:0] wr_seen_q;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wr_seen_q <= 5'h00;
    else if (opc_hit && !s_q.busy)
      wr_seen_q <= 5'h00;
    else if (s_q.wr_en)
      wr_seen_q <= wr_seen_q + 5'h01;
  end

  xfer_count_a: assert property ( // (R1)
    @(posedge mclk) disable iff (!rstn)
    $rose(s_q.done) |-> wr_seen_q == 5'h10)
    else $error("transfer did not write sixteen bytes");

  ptr_step_a: assert property ( // (R1)
    @(posedge mclk) disable iff (!rstn)
    s_q.wr_en ##1 !s_q.wr_en ##1 s_q.wr_en |->
      s_q.wr_addr == $past(s_q.wr_addr, 2) + 16'h0001)
    else $error("write address did not step by one");

  xfer_len_a: assert property ( // (R2)
    @(posedge mclk) disable iff (!rstn)
    (opc_hit && !s_q.busy) |=> s_q.busy [*8] ##33 s_q.done)
    else $error("transfer length is not forty clocks");

  int_hold_a: assert property ( // (R3)
    @(posedge mclk) disable iff (!rstn)
    s_q.done |-> s_q.inhibit)
    else $error("interrupts allowed at transfer end");

  rsvd_zero_a: assert property ( // (R9)
    @(posedge mclk) disable iff (!rstn)
    (s_q.wr_en && (wr_seen_q == 5'h0a || wr_seen_q == 5'h0b)) |->
      s_q.wr_data == sst_pkg::ZERO_BYTE)
    else $error("reserved byte written non-zero");

  // Address store has no reset, so only check once a trap filled it
  logic trap_seen_q;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      trap_seen_q <= 1'b0;
    else if (wprot_ev || xinh_ev || ill4_trap || ill2_trap)
      trap_seen_q <= 1'b1;
  end

  trap_keep_a: assert property ( // (R5)
    @(posedge mclk) disable iff (!rstn)
    trap_seen_q && !(wprot_ev || xinh_ev || ill4_trap || ill2_trap) |=>
      $stable(a_q.trap_laddr))
    else $error("trap address changed without a trap");

  set_wins_a: assert property ( // (R23)
    @(posedge mclk) disable iff (!rstn)
    (clr && fatal_detect) |=> s_q.reset_cause[sst_pkg::RC_FATAL])
    else $error("coinciding event lost on clear");

  wp_clear_a: assert property ( // (R14)
    @(posedge mclk) disable iff (!rstn)
    clr |=> !s_q.trap_cause[sst_pkg::TC_WPROT])
    else $error("write-protect flag survived transfer end");

  strobe_a: assert property ( // (R22)
    @(posedge mclk) disable iff (!rstn)
    s_q.done |=> s_q.rd_strobe ##1 !s_q.rd_strobe)
    else $error("read strobe not one clock after end");

  sat_a: assert property ( // (R15)
    @(posedge mclk) disable iff (!rstn)
    (!clr && s_q.dma_byte == sst_pkg::SAT_BYTE) |=>
      s_q.dma_byte == sst_pkg::SAT_BYTE)
    else $error("dma byte wrapped");

endmodule : sst_status_block

// ===== dv/sst_core_model.sv
// Core model issuing status transfers and capturing the block writes
`timescale 1ns/10ps
module sst_core_model (
  // Clock
  input  wire logic        mclk,
  // Instruction issue
  output logic             instr_start,
  output logic [7:0]       opcode_byte0,
  output logic [7:0]       opcode_byte1,
  output logic             instr_end,
  output logic [15:0]      pointer_register,
  // Block write port
  input  wire logic        mem_wr_en,
  input  wire logic [15:0] mem_wr_addr,
  input  wire logic [7:0]  mem_wr_data
);
  logic [7:0] mem [logic [15:0]];
  int         wr_count = 0;

  initial
  begin
    instr_start = 1'b0;
    instr_end   = 1'b0;
    {opcode_byte0, opcode_byte1, pointer_register} = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-byte opcode issue
  task automatic start(input logic [7:0] op0, input logic [7:0] op1,
                       input logic [15:0] ptr);
    instr_start      = 1'b1;
    opcode_byte0     = op0;
    opcode_byte1     = op1;
    pointer_register = ptr;
  endtask : start

  // Scrambled after the start edge, so a late resample shows up
  task automatic stop();
    instr_start      = 1'b0;
    opcode_byte0     = ~opcode_byte0;
    opcode_byte1     = ~opcode_byte1;
    pointer_register = ~pointer_register;
  endtask : stop

  task automatic finish(input logic on);
    instr_end = on;
  endtask : finish

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    if (mem_wr_en === 1'b1)
    begin
      mem[mem_wr_addr] = mem_wr_data;
      wr_count++;
    end
  end
endmodule : sst_core_model

// ===== dv/system_status_block_tb.sv
// Self-checking bench for the system status block
`timescale 1ns/10ps
module system_status_block_tb;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        instr_start, instr_end;
  logic [7:0]  opcode_byte0, opcode_byte1, mem_wr_data, ext_stat;
  logic [15:0] pointer_register, mem_wr_addr, pointer_next;
  logic [15:0] instr_laddr, mem_laddr, tl, fl;
  logic [27:0] instr_paddr, mem_paddr, tp, fp;
  logic        xfer_busy, xfer_done, mem_wr_en, int_inhibit, ext_stat_rd;
  logic        ill2_trap, ill4_trap, fetch_first, exec_inh, mem_write;
  logic        wr_inh, fatal_detect, fault_detect, wdt_timeout;
  logic        dma_timeout, wait_timeout, ref_clock;
  logic [1:0]  reset_bus;
  logic [4:0]  rti;
  logic [7:0]  rc, tc, dma_f, wait_f;
  logic [7:0]  exp_blk [16];
  logic [15:0] bad [3] = '{16'hed9b, 16'hec9a, 16'h9aed};
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n;
  integer      seed = 32'h257d;

  sst_status_block sst_status_block_inst (
    .mclk(mclk), .rstn(rstn), .instr_start(instr_start),
    .opcode_byte0(opcode_byte0), .opcode_byte1(opcode_byte1),
    .instr_end(instr_end), .pointer_register(pointer_register),
    .xfer_busy(xfer_busy), .xfer_done(xfer_done), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .pointer_next(pointer_next), .int_inhibit(int_inhibit),
    .ext_stat_rd(ext_stat_rd), .ill2_trap(ill2_trap), .ill4_trap(ill4_trap),
    .instr_laddr(instr_laddr), .instr_paddr(instr_paddr),
    .fetch_first(fetch_first), .exec_inh(exec_inh), .mem_write(mem_write),
    .wr_inh(wr_inh), .mem_laddr(mem_laddr), .mem_paddr(mem_paddr),
    .fatal_detect(fatal_detect), .fault_detect(fault_detect),
    .wdt_timeout(wdt_timeout), .reset_bus(reset_bus),
    .dma_timeout(dma_timeout), .wait_timeout(wait_timeout),
    .ref_clock(ref_clock), .rti_div_small(rti[4]),
    .rti_ref_present(rti[3]), .rti_synced(rti[2]),
    .rti_dflt_small(rti[1]), .rti_dflt_used(rti[0]), .ext_stat(ext_stat));

  sst_core_model core_inst (
    .mclk(mclk), .instr_start(instr_start), .opcode_byte0(opcode_byte0),
    .opcode_byte1(opcode_byte1), .instr_end(instr_end),
    .pointer_register(pointer_register), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));

  always #20 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [7:0] blk(input int k, input logic [7:0] snap);
    case (k)
      0: blk = rc | {4'h0, reset_bus[1], 1'b0, reset_bus[0], 1'b0};
      1: blk = tc;
      2: blk = tl[7:0];
      3: blk = tl[15:8];
      4: blk = tp[19:12];
      5: blk = tp[27:20];
      6: blk = fl[7:0];
      7: blk = fl[15:8];
      8: blk = fp[19:12];
      9: blk = fp[27:20];
      12: blk = dma_f;
      13: blk = wait_f;
      14: blk = {2'b00, ref_clock, rti};
      15: blk = snap;
      default: blk = 8'h00;
    endcase
  endfunction : blk

  // Reset sets the power-on flag, clears the other sticky flags and logs any high reset line
  task automatic do_reset(input int len);
    rstn = 1'b0;
    repeat (len) @(negedge mclk);
    rstn = 1'b1;
    rc = {3'b000, 1'b1, 2'b00, 1'b0, 1'b0} | {5'h0, reset_bus[1], 1'b0,
         reset_bus[0]};
    {tc, dma_f, wait_f} = 24'h0;
  endtask : do_reset

  task automatic events(input logic [7:0] e, input logic [1:0] t);
    @(negedge mclk);
    {instr_laddr, mem_laddr} = $random(seed);
    instr_paddr = $random(seed);
    mem_paddr = $random(seed);
    {fatal_detect, fault_detect, wdt_timeout} = {e[0], e[1], e[2]};
    reset_bus = reset_bus ^ e[4:3];
    {dma_timeout, wait_timeout} = {e[5], e[6]};
    {ill2_trap, ill4_trap} = {e[7] && t == 2'd0, e[7] && t == 2'd1};
    {fetch_first, exec_inh} = {2{e[7] && t == 2'd2}};
    {mem_write, wr_inh} = {2{e[7] && t == 2'd3}};
    rc = rc | {e[0], e[1], e[2], 2'b00, e[4], 1'b0, e[3]};
    if (e[1])
      {fl, fp} = {mem_laddr, mem_paddr};
    dma_f = dma_f | {7'h0, e[5]};
    wait_f = wait_f | {7'h0, e[6]};
    if (e[7])
    begin
      tc[t] = 1'b1;
      {tl, tp} = (t >= 2'd2) ? {mem_laddr, mem_paddr} : {instr_laddr,
                 instr_paddr};
      if (t == 2'd1)
        {tl, tp} = {tl + 16'h2, tp + 28'h2};
    end
    @(negedge mclk);
    {fatal_detect, fault_detect, wdt_timeout, dma_timeout} = 4'h0;
    {wait_timeout, ill2_trap, ill4_trap, fetch_first} = 4'h0;
    {exec_inh, mem_write, wr_inh} = 3'h0;
  endtask : events

  // Poke reissues the opcode mid-run, which is ignored; coinc raises events on the clearing edge
  task automatic xfer(input logic poke, input int gap, input logic coinc);
    logic [15:0] ptr;
    int          base;
    ptr = $random(seed);
    base = core_inst.wr_count;
    for (int k = 0; k < 16; k++)
      exp_blk[k] = blk(k, ext_stat);
    core_inst.start(sst_pkg::OPC_PREFIX, sst_pkg::OPC_XFER, ptr);
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
      if (n == 1 || n == 11)
        core_inst.stop();
      if (n == 1)
        check({15'h0, xfer_busy}, 16'h1);
      if (n == 2)
        ext_stat = ~ext_stat;
      if (poke && n == 10)
        core_inst.start(sst_pkg::OPC_PREFIX, sst_pkg::OPC_XFER, ~ptr);
      {fatal_detect, mem_write, wr_inh} = {3{coinc && n == 40}};
    end while (xfer_done !== 1'b1 && n < 60);
    check(16'(n), 16'd41);
    check({14'h0, xfer_busy, xfer_done}, 16'h1);
    check(pointer_next, ptr + 16'h10);
    @(negedge mclk);
    check({15'h0, ext_stat_rd}, 16'h1);
    repeat (gap) @(negedge mclk);
    check({14'h0, ext_stat_rd, int_inhibit}, 16'h1);
    core_inst.finish(1'b1);
    @(negedge mclk);
    core_inst.finish(1'b0);
    @(negedge mclk);
    check({15'h0, int_inhibit}, 16'h0);
    check(16'(core_inst.wr_count - base), 16'd16);
    for (int k = 0; k < 16; k++)
      if (!$isunknown(exp_blk[k]))
        check(core_inst.mem[ptr + k], exp_blk[k]);
    {rc, tc, dma_f, wait_f} = 32'h0;
    if (coinc)
      {rc, tl, tp} = {8'h80, mem_laddr, mem_paddr};
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {instr_laddr, mem_laddr, instr_paddr, mem_paddr} = 88'h0;
    {ill2_trap, ill4_trap, fetch_first, exec_inh, mem_write} = 5'h0;
    {wr_inh, fatal_detect, fault_detect, wdt_timeout} = 4'h0;
    {dma_timeout, wait_timeout, ref_clock, reset_bus, rti} = 10'h0;
    ext_stat = 8'h5a;
    do_reset(16);
    xfer(1'b0, 1, 1'b0);
    xfer(1'b1, 3, 1'b0);
    $display("power-on and refusal test done");
    foreach (bad[i])
    begin
      base_check: begin
        n = core_inst.wr_count;
        @(negedge mclk);
        core_inst.start(bad[i][15:8], bad[i][7:0], 16'h1234);
        @(negedge mclk);
        core_inst.stop();
        repeat (45) @(negedge mclk);
        check(16'(core_inst.wr_count - n), 16'h0);
      end
    end
    $display("wrong opcode test done");
    for (int r = 0; r < 8; r++)
    begin
      ext_stat = $random(seed);
      {ref_clock, rti} = $random(seed);
      repeat (3) events($random(seed), $random(seed));
      if (r == 7)
        events(8'hff, 2'd1);
      xfer(r[0], r + 1, r == 3);
      $display("event round %0d done", r);
    end
    do_reset(3);
    xfer(1'b0, 2, 1'b0);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule : system_status_block_tb
